/* File: cmpcal_pkg.sv */
/*
 * cmpcal_pkg: register offsets, field positions, reset values and states
 * of the comparator offset calibration and interrupt block.
 * Assumes a 32-bit APB register bus with one register per aligned word.
 */
package cmpcal_pkg;
	localparam int ADDR_W = 8;
	localparam int TRIM_W = 5;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TRIM = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_TRIP = 8'h14;
	localparam logic [7:0] OFF_PORT = 8'h18;

	// control register fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_INV = 1;
	localparam int CTRL_CAL = 2;
	localparam int CTRL_REF = 3;
	localparam int CTRL_START = 4;
	localparam int CTRL_MFEN = 5;
	localparam int CTRL_PINSEL = 6;

	// trim register fields
	localparam int TRIM_LSB = 0;
	localparam int TRIM_CAL = 5;
	localparam int TRIM_REF = 6;

	// status register fields
	localparam int STAT_RESULT = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_SLEEP = 2;

	// interrupt status / mask fields
	localparam int IRQ_CHANGE = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_W = 2;

	localparam logic [4:0] TRIM_RESET = 5'h10;
	localparam logic [4:0] TRIM_LOW = 5'h00;
	localparam logic [4:0] TRIM_HIGH = 5'h1f;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;

	// cycles allowed for the analog comparator to settle after a trim step
	localparam int SETTLE_NS = 40;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYC - 1);

	typedef enum logic [2:0] {
		CMPCAL_IDLE,
		CMPCAL_UP_SEED,
		CMPCAL_UP_STEP,
		CMPCAL_DN_SEED,
		CMPCAL_DN_STEP,
		CMPCAL_FINISH
	} cmpcal_state_t;
endpackage

/* File: cmpcal_sync.sv */
/*
 * cmpcal_sync: two-flop synchroniser for the raw analog comparator output.
 * Assumes the comparator output is asynchronous to MCLK.
 */
`timescale 1ns/1ps
module cmpcal_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic d,
	output logic q
);
	logic meta;
	logic next_meta;
	logic next_q;

	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule // cmpcal_sync

/* File: cmpcal_top.sv */
/*
 * cmpcal_top: digital control around an analog comparator: trim field,
 * hardware offset calibration search, result polarity, change interrupt,
 * wake-up and pin-shared I/O read masking, with an APB register slave.
 * Assumes a single 250 MHz clock MCLK, asynchronous active-low RESETN,
 * and that the analog comparator output settles within SETTLE_NS.
 */
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
module cmpcal_top
	import cmpcal_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [cmpcal_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CMP_RAW,
	input wire logic CORE_SLEEP,
	input wire logic [7:0] PORT_IN,
	output logic CMP_ENABLE,
	output logic [4:0] TRIM_CODE,
	output logic CAL_MODE,
	output logic CAL_REF_POS,
	output logic PIN_SHARED,
	output logic CMP_PIN_OUT,
	output logic IRQ,
	output logic VECTOR_REQ,
	output logic WAKEUP
);
	import cmpcal_pkg::*;

	function automatic logic [4:0] step_up(input logic [4:0] c);
		step_up = (c == TRIM_HIGH) ? c : 5'(c + 5'h01);
	endfunction

	function automatic logic [4:0] step_dn(input logic [4:0] c);
		step_dn = (c == TRIM_LOW) ? c : 5'(c - 5'h01);
	endfunction

	logic cmp_sync;
	cmpcal_sync u_sync (
		.clk(MCLK),
		.resetn(RESETN),
		.d(CMP_RAW),
		.q(cmp_sync)
	);

	// registers
	logic cmp_en, result_invert, cal_mode_select, cal_reference_select, mf_en, pin_sel;
	logic [4:0] offset_trim_code;
	logic [4:0] lower_trip_code, upper_trip_code;
	logic [IRQ_W-1:0] irq_stat, irq_mask;
	logic cmp_result_bit, result_prev;
	cmpcal_state_t state;
	logic [3:0] settle;
	logic [31:0] rdata;
	logic ready, irq_q, vec_q, wake_q, pin_q;

	logic next_cmp_en, next_result_invert, next_cal_mode_select, next_cal_reference_select;
	logic next_mf_en, next_pin_sel;
	logic [4:0] next_offset_trim_code, next_lower_trip_code, next_upper_trip_code;
	logic [IRQ_W-1:0] next_irq_stat, next_irq_mask;
	logic next_cmp_result_bit, next_result_prev;
	cmpcal_state_t next_state;
	logic [3:0] next_settle;
	logic [31:0] next_rdata;
	logic next_ready, next_irq_q, next_vec_q, next_wake_q, next_pin_q;

	logic wr, rd, busy, changed, done_ev, start;
	logic [5:0] trip_sum;
	logic [4:0] trim_midpoint;

	always_comb begin
		// writes commit on the edge that completes the transfer, with PREADY high
		wr = PSEL && PENABLE && PWRITE && ready;
		rd = PSEL && PENABLE && !PWRITE && !ready;
		busy = (state != CMPCAL_IDLE);
		// interrupt from the result bit itself, so polarity flips count
		changed = (cmp_result_bit != result_prev);
		trip_sum = 6'({1'b0, lower_trip_code} + {1'b0, upper_trip_code});
		trim_midpoint = trip_sum[5:1];
		start = wr && PADDR == OFF_CTRL && PWDATA[CTRL_START] && PWDATA[CTRL_CAL];
	end

	// control and trim registers; trim writes ignored while search is busy
	always_comb begin
		next_cmp_en = cmp_en;
		next_result_invert = result_invert;
		next_cal_mode_select = cal_mode_select;
		next_cal_reference_select = cal_reference_select;
		next_mf_en = mf_en;
		next_pin_sel = pin_sel;
		next_offset_trim_code = offset_trim_code;
		next_irq_mask = irq_mask;
		if (wr && PADDR == OFF_CTRL) begin
			next_cmp_en = PWDATA[CTRL_EN];
			next_result_invert = PWDATA[CTRL_INV];
			next_cal_mode_select = PWDATA[CTRL_CAL];
			next_cal_reference_select = PWDATA[CTRL_REF];
			next_mf_en = PWDATA[CTRL_MFEN];
			next_pin_sel = PWDATA[CTRL_PINSEL];
		end
		if (wr && PADDR == OFF_TRIM && !busy) begin
			next_offset_trim_code = PWDATA[TRIM_LSB +: TRIM_W];
			next_cal_mode_select = PWDATA[TRIM_CAL];
			next_cal_reference_select = PWDATA[TRIM_REF];
		end
		if (wr && PADDR == OFF_MASK)
			next_irq_mask = PWDATA[IRQ_W-1:0];
		case (state)
			CMPCAL_UP_SEED: next_offset_trim_code = TRIM_LOW;
			CMPCAL_UP_STEP:
				if (settle == 4'h0 && !changed)
					next_offset_trim_code = step_up(offset_trim_code);
			CMPCAL_DN_SEED: next_offset_trim_code = TRIM_HIGH;
			CMPCAL_DN_STEP:
				if (settle == 4'h0 && !changed)
					next_offset_trim_code = step_dn(offset_trim_code);
			CMPCAL_FINISH: next_offset_trim_code = trim_midpoint;
			default: ;
		endcase
	end

	// calibration search; the reference is the seeded result of each pass
	always_comb begin
		next_state = state;
		next_settle = settle;
		next_lower_trip_code = lower_trip_code;
		next_upper_trip_code = upper_trip_code;
		next_result_prev = cmp_result_bit;
		done_ev = 1'b0;
		case (state)
			CMPCAL_IDLE: begin
				if (start) begin
					next_state = CMPCAL_UP_SEED;
				end
			end
			CMPCAL_UP_SEED: begin
				next_settle = SETTLE_LOAD;
				next_state = CMPCAL_UP_STEP;
			end
			CMPCAL_UP_STEP: begin
				// reference is the settled result of the seed code only
				next_result_prev = result_prev;
				if (settle != 4'h0) begin
					next_settle = 4'(settle - 4'h1);
					if (settle == 4'h1 && offset_trim_code == TRIM_LOW)
						next_result_prev = cmp_result_bit;
				end else if (changed || offset_trim_code == TRIM_HIGH) begin
					next_lower_trip_code = offset_trim_code;
					next_state = CMPCAL_DN_SEED;
				end else begin
					next_settle = SETTLE_LOAD;
				end
			end
			CMPCAL_DN_SEED: begin
				next_settle = SETTLE_LOAD;
				next_state = CMPCAL_DN_STEP;
			end
			CMPCAL_DN_STEP: begin
				next_result_prev = result_prev;
				if (settle != 4'h0) begin
					next_settle = 4'(settle - 4'h1);
					if (settle == 4'h1 && offset_trim_code == TRIM_HIGH)
						next_result_prev = cmp_result_bit;
				end else if (changed || offset_trim_code == TRIM_LOW) begin
					next_upper_trip_code = offset_trim_code;
					next_state = CMPCAL_FINISH;
				end else begin
					next_settle = SETTLE_LOAD;
				end
			end
			CMPCAL_FINISH: begin
				done_ev = 1'b1;
				next_state = CMPCAL_IDLE;
			end
			default: next_state = CMPCAL_IDLE;
		endcase
		// a start written together with the mode bit is not aborted
		if (!next_cal_mode_select)
			next_state = CMPCAL_IDLE;
	end

	// result bit, sticky flags, outputs
	always_comb begin
		// comparator keeps sampling in sleep when enabled
		next_cmp_result_bit = cmp_en ? (cmp_sync ^ result_invert) : 1'b0;
		next_irq_stat = irq_stat;
		if (wr && PADDR == OFF_IRQ)
			next_irq_stat = irq_stat & ~PWDATA[IRQ_W-1:0];
		// set beats a same-cycle clear; software may also set to block wake
		if (wr && PADDR == OFF_STAT)
			next_irq_stat = next_irq_stat | PWDATA[IRQ_W-1:0];
		if (changed && !busy && cmp_en)
			next_irq_stat[IRQ_CHANGE] = 1'b1;
		if (done_ev)
			next_irq_stat[IRQ_DONE] = 1'b1;
		next_irq_q = |(next_irq_stat & irq_mask);
		next_vec_q = next_irq_stat[IRQ_CHANGE] && irq_mask[IRQ_CHANGE] && mf_en;
		// only a fresh flag edge wakes, so a preset flag suppresses it
		next_wake_q = CORE_SLEEP && cmp_en && changed && !busy
			&& !irq_stat[IRQ_CHANGE];
		next_pin_q = cmp_en ? cmp_result_bit : 1'b0;
		next_ready = PSEL && PENABLE && !ready;
		next_rdata = 32'h0;
		if (rd) begin
			case (PADDR)
				OFF_CTRL: next_rdata = 32'({pin_sel, mf_en, 1'b0, cal_reference_select,
					cal_mode_select, result_invert, cmp_en});
				OFF_TRIM: next_rdata = 32'({cal_reference_select, cal_mode_select,
					offset_trim_code});
				OFF_STAT: next_rdata = 32'({CORE_SLEEP, busy, cmp_result_bit});
				OFF_IRQ: next_rdata = 32'(irq_stat);
				OFF_MASK: next_rdata = 32'(irq_mask);
				OFF_TRIP: next_rdata = 32'({upper_trip_code, 3'h0, lower_trip_code});
				// pin-shared data reads zero while the comparator owns the pins
				OFF_PORT: next_rdata = 32'((cmp_en && pin_sel) ? 8'h00 : PORT_IN);
				default: next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			cmp_en <= CTRL_RESET[CTRL_EN];
			result_invert <= CTRL_RESET[CTRL_INV];
			cal_mode_select <= CTRL_RESET[CTRL_CAL];
			cal_reference_select <= CTRL_RESET[CTRL_REF];
			mf_en <= CTRL_RESET[CTRL_MFEN];
			pin_sel <= CTRL_RESET[CTRL_PINSEL];
			offset_trim_code <= TRIM_RESET;
			lower_trip_code <= TRIM_LOW;
			upper_trip_code <= TRIM_LOW;
			irq_stat <= '0;
			irq_mask <= MASK_RESET;
			cmp_result_bit <= 1'b0;
			result_prev <= 1'b0;
			state <= CMPCAL_IDLE;
			settle <= 4'h0;
			rdata <= 32'h0;
			ready <= 1'b0;
			irq_q <= 1'b0;
			vec_q <= 1'b0;
			wake_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			cmp_en <= next_cmp_en;
			result_invert <= next_result_invert;
			cal_mode_select <= next_cal_mode_select;
			cal_reference_select <= next_cal_reference_select;
			mf_en <= next_mf_en;
			pin_sel <= next_pin_sel;
			offset_trim_code <= next_offset_trim_code;
			lower_trip_code <= next_lower_trip_code;
			upper_trip_code <= next_upper_trip_code;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			cmp_result_bit <= next_cmp_result_bit;
			result_prev <= next_result_prev;
			state <= next_state;
			settle <= next_settle;
			rdata <= next_rdata;
			ready <= next_ready;
			irq_q <= next_irq_q;
			vec_q <= next_vec_q;
			wake_q <= next_wake_q;
			pin_q <= next_pin_q;
		end
	end

	// mirrored control outputs, registered copies kept in step
	logic en_o, cal_o, ref_o, pin_o;
	logic [4:0] trim_o;
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			en_o <= 1'b0;
			cal_o <= 1'b0;
			ref_o <= 1'b0;
			pin_o <= 1'b0;
			trim_o <= TRIM_RESET;
		end else begin
			en_o <= next_cmp_en;
			cal_o <= next_cal_mode_select;
			ref_o <= next_cal_reference_select;
			pin_o <= next_pin_sel;
			trim_o <= next_offset_trim_code;
		end
	end

	always_comb begin
		PRDATA = rdata;
		PREADY = ready;
		PSLVERR = 1'b0;
		CMP_ENABLE = en_o;
		TRIM_CODE = trim_o;
		CAL_MODE = cal_o;
		CAL_REF_POS = ref_o;
		PIN_SHARED = pin_o;
		CMP_PIN_OUT = pin_q;
		IRQ = irq_q;
		VECTOR_REQ = vec_q;
		WAKEUP = wake_q;
	end
endmodule // cmpcal_top

/* File: cmpcal_top_props.sv */
/* cmpcal_props: port checker for cmpcal_top.
 * Assumes cmpcal_pkg is compiled first; bound below to every cmpcal_top. */
`timescale 1ns/1ps
module cmpcal_props
	import cmpcal_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [cmpcal_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CORE_SLEEP,
	input wire logic CMP_ENABLE,
	input wire logic [4:0] TRIM_CODE,
	input wire logic CAL_MODE,
	input wire logic IRQ,
	input wire logic VECTOR_REQ,
	input wire logic WAKEUP
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	wire logic wr = PSEL && PENABLE && PREADY && PWRITE;
	wire logic trim_wr = wr && PADDR == OFF_TRIM;
	ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("no ready after wait");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
	no_error_a: assert property (!PSLVERR) else $error("error response");
	start_zero_a: assert property (wr && PADDR == OFF_CTRL && PWDATA[CTRL_START]
		&& PWDATA[CTRL_CAL] |-> ##[1:3] TRIM_CODE == TRIM_LOW) else $error("search not at zero");
	trim_hold_a: assert property ($changed(TRIM_CODE) && !CAL_MODE && !$past(CAL_MODE)
		|-> $past(trim_wr)) else $error("trim moved without write");
	no_wrap_a: assert property (CAL_MODE && $past(CAL_MODE) && $past(TRIM_CODE) == TRIM_LOW
		|-> TRIM_CODE != TRIM_HIGH) else $error("trim wrapped");
	vector_irq_a: assert property (VECTOR_REQ |-> IRQ)
		else $error("vector without irq");
	wake_cause_a: assert property (WAKEUP |-> CMP_ENABLE && (CORE_SLEEP || $past(CORE_SLEEP)))
		else $error("wake while awake or off");
endmodule // cmpcal_props

bind cmpcal_top cmpcal_props u_props (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .CORE_SLEEP(CORE_SLEEP), .CMP_ENABLE(CMP_ENABLE),
	.TRIM_CODE(TRIM_CODE), .CAL_MODE(CAL_MODE), .IRQ(IRQ), .VECTOR_REQ(VECTOR_REQ),
	.WAKEUP(WAKEUP));

/* File: cmpcal_top_tb.sv */
/* cmpcal_top_tb: register level tests of cmpcal_top over APB.
 * Assumes cmpcal_pkg and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(s, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", s, e, g); end end
module cmpcal_top_tb;
	import cmpcal_pkg::*;
	logic mclk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic raw = 1'h0, sleep = 1'h0, follow = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] thr = 6'h20;
	logic [31:0] prdata, rd;
	logic pready, cmp_en, cal_mode, ref_pos, irq, vreq, wakeup, pin_sh, pin_out;
	logic [4:0] trim;
	int n_fail = 0, tests_run = 0, wakes = 0;
	cmpcal_top u_dut (.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(), .CMP_RAW(raw), .CORE_SLEEP(sleep), .PORT_IN(8'ha5),
		.CMP_ENABLE(cmp_en), .TRIM_CODE(trim), .CAL_MODE(cal_mode), .CAL_REF_POS(ref_pos),
		.PIN_SHARED(pin_sh), .CMP_PIN_OUT(pin_out), .IRQ(irq), .VECTOR_REQ(vreq),
		.WAKEUP(wakeup));
	initial forever #2 mclk = ~mclk;
	// analog stand-in: trips once the trim code reaches thr
	always @(posedge mclk) if (follow) raw <= ({1'h0, trim} >= thr);
	always @(posedge mclk) if (wakeup === 1'h1) wakes <= wakes + 1;
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#60000;
		n_fail++;
		complete_run;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 40);
		if (n >= 40) n_fail++;
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		// idle edge keeps the next setup from reassigning psel in this step
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		`CHK(s, e, rd)
	endtask
	task automatic cal(input logic [5:0] t, input logic [31:0] trip, input logic [4:0] mid);
		int n;
		n = 0;
		thr <= t;
		follow <= 1'h1;
		wr(OFF_CTRL, 32'h41);
		wr(OFF_CTRL, 32'h45);
		`CHK("cal mode", 1'h1, cal_mode)
		wr(OFF_IRQ, 32'h3);
		wr(OFF_CTRL, 32'h55);
		wr(OFF_TRIM, 32'h3b);
		do begin
			apb(1'h0, OFF_STAT, 32'h0);
			n++;
		end while (rd[STAT_BUSY] !== 1'h0 && n < 400);
		if (n >= 400) n_fail++;
		rdc("trip", OFF_TRIP, trip);
		`CHK("trim mid", mid, trim)
		rdc("done", OFF_IRQ, 32'h2);
		$display("test calibration done");
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'h1;
		rdc("trim rst", OFF_TRIM, 32'h10);
		rdc("mask rst", OFF_MASK, 32'h0);
		wr(OFF_TRIM, 32'h47);
		`CHK("trim", 5'h07, trim)
		`CHK("ref", 1'h1, ref_pos)
		`CHK("mode", 1'h0, cal_mode)
		$display("test registers done");
		cal(6'h0d, 32'h0c0d, 5'h0c);
		cal(6'h20, 32'h001f, 5'h0f);
		follow <= 1'h0;
		wr(OFF_CTRL, 32'h61);
		wr(OFF_MASK, 32'h3);
		`CHK("pin shared", 1'h1, pin_sh)
		wr(OFF_IRQ, 32'h3);
		@(posedge mclk);
		`CHK("irq off", 1'h0, irq)
		raw <= 1'h1;
		rdc("unmapped", 8'h1c, 32'h0);
		rdc("result", OFF_STAT, 32'h1);
		`CHK("pin out", 1'h1, pin_out)
		rdc("flag", OFF_IRQ, 32'h1);
		`CHK("irq on", 1'h1, irq)
		`CHK("vector", 1'h1, vreq)
		wr(OFF_CTRL, 32'h41);
		wr(OFF_MASK, 32'h1);
		`CHK("vector off", 1'h0, vreq)
		wr(OFF_MASK, 32'h0);
		@(posedge mclk);
		`CHK("masked", 1'h0, irq)
		wr(OFF_MASK, 32'h1);
		wr(OFF_CTRL, 32'h43);
		rdc("inverted", OFF_STAT, 32'h0);
		wr(OFF_IRQ, 32'h1);
		@(posedge mclk);
		`CHK("cleared", 1'h0, irq)
		$display("test interrupt done");
		sleep <= 1'h1;
		raw <= 1'h0;
		rdc("unmapped", 8'h1c, 32'h0);
		rdc("sleep flag", OFF_IRQ, 32'h1);
		`CHK("wake", 32'h1, wakes)
		wr(OFF_IRQ, 32'h1);
		wr(OFF_STAT, 32'h1);
		rdc("preset", OFF_IRQ, 32'h1);
		raw <= 1'h1;
		rdc("unmapped", 8'h1c, 32'h0);
		rdc("sleep stat", OFF_STAT, 32'h4);
		`CHK("no wake", 32'h1, wakes)
		rdc("port shared", OFF_PORT, 32'h0);
		sleep <= 1'h0;
		wr(OFF_CTRL, 32'h40);
		`CHK("disabled", 1'h0, cmp_en)
		rdc("port", OFF_PORT, 32'ha5);
		$display("test sleep and port done");
		complete_run;
	end
endmodule // cmpcal_top_tb
